// file: design/csp_pkg.sv
// Package: constants and types for the core status/config/PC block.
// Assumes one CLK domain, one instruction step per strobe from the core.
package csp_pkg;
	localparam logic [4:0] ADDR_PC_LOW      = 5'h02;
	localparam logic [4:0] ADDR_ALU_STATUS  = 5'h03;
	localparam logic [8:0] PC_RESET_VECTOR  = 9'h1ff;
	localparam logic [5:0] CFG_RESET        = 6'h3f;
	localparam logic [7:0] STATUS_RESET     = 8'h18;
	localparam int         CFG_SRC_BIT      = 5;
	localparam int         CFG_EDGE_BIT     = 4;
	localparam int         CFG_ASSIGN_BIT   = 3;
	localparam int         STAT_TO_BIT      = 4;
	localparam int         STAT_PD_BIT      = 3;
	localparam int         STAT_Z_BIT       = 2;
	localparam int         STAT_DC_BIT      = 1;
	localparam int         STAT_C_BIT       = 0;

	// Program counter action chosen by the decoder
	typedef enum logic [2:0] {
		CSP_PC_INC  = 3'b000,
		CSP_PC_JUMP = 3'b001,
		CSP_PC_CALL = 3'b010,
		CSP_PC_RET  = 3'b011,
		CSP_PC_HOLD = 3'b100
	} csp_pc_op_t;

	// Flag update class of the executing instruction
	typedef enum logic [1:0] {
		CSP_FL_NONE = 2'b00,
		CSP_FL_Z    = 2'b01,
		CSP_FL_ZCD  = 2'b10,
		CSP_FL_ROT  = 2'b11
	} csp_flag_op_t;
endpackage

// file: design/csp_rate_dec.sv
// Prescale rate decoder: rate code to one-hot tap of a divide chain.
// Assumes the caller owns the prescaler counter itself.
`timescale 1ns/1ps
module csp_rate_dec
(
	input  wire logic [2:0] code,
	output logic      [7:0] tap
);
	// Code 0 is 1:2, each step doubles, code 7 is 1:256
	always_comb
	begin
		tap = 8'h01 << code;
	end
endmodule // csp_rate_dec

// file: design/csp_pc_next.sv
// Next program counter selector.
// Assumes the caller registers the result.
`timescale 1ns/1ps
module csp_pc_next
(
	input  wire logic [8:0]          pc,
	input  wire csp_pkg::csp_pc_op_t op,
	input  wire logic [8:0]          lit,
	input  wire logic [8:0]          ret_addr,
	input  wire logic                pcl_wr,
	input  wire logic [7:0]          pcl_data,
	output logic      [8:0]          pc_nxt
);
	always_comb
	begin
		if (pcl_wr)
			pc_nxt = {1'b0, pcl_data};
		else
		begin
			case (op)
				csp_pkg::CSP_PC_JUMP: pc_nxt = lit;
				csp_pkg::CSP_PC_CALL: pc_nxt = {1'b0, lit[7:0]};
				csp_pkg::CSP_PC_RET:  pc_nxt = ret_addr;
				csp_pkg::CSP_PC_HOLD: pc_nxt = pc;
				default:              pc_nxt = pc + 9'h001;
			endcase
		end
	end
endmodule // csp_pc_next

// file: design/csp_core.sv
// Core status, prescale configuration and program counter.
// Assumes the instruction core gives one STEP pulse per instruction
// cycle with decoded controls valid in that cycle.
`timescale 1ns/1ps
module csp_core
(
	input  wire logic                  CLK,
	input  wire logic                  RST_N,
	input  wire logic                  STEP,
	input  wire csp_pkg::csp_pc_op_t   PC_OP,
	input  wire logic [8:0]            LIT,
	input  wire logic [8:0]            RET_ADDR,
	input  wire logic                  CFG_LOAD,
	input  wire logic [7:0]            WREG,
	input  wire logic                  FILE_WR,
	input  wire logic [4:0]            FILE_ADDR,
	input  wire logic [7:0]            FILE_WDATA,
	input  wire csp_pkg::csp_flag_op_t FLAG_OP,
	input  wire logic [7:0]            RESULT,
	input  wire logic                  CARRY_IN,
	input  wire logic                  DCARRY_IN,
	input  wire logic [7:0]            ROT_OPERAND,
	input  wire logic                  ROT_LEFT,
	input  wire logic                  TIMEOUT_SET,
	input  wire logic                  TIMEOUT_CLR,
	input  wire logic                  POWERDOWN_SET,
	input  wire logic                  POWERDOWN_CLR,
	output logic      [8:0]            PC,
	output logic      [7:0]            ALU_STATUS,
	output logic      [7:0]            PC_LOW_READ,
	output logic                       TIMER_SOURCE_SELECT,
	output logic                       TIMER_EDGE_SELECT,
	output logic                       PRESCALER_ASSIGN,
	output logic      [7:0]            PRESCALE_TAP
);
	typedef struct packed {
		logic [8:0] pc;
		logic [7:0] status;
		logic [5:0] cfg;
		logic [7:0] tap;
	} csp_state_t;

	csp_state_t st_r;
	csp_state_t st_nxt;
	logic [8:0] pc_sel;
	logic [7:0] tap_dec;
	logic [5:0] cfg_nxt;
	logic       pcl_wr;
	logic       stat_wr;

	// Low counter byte write forces a computed jump
	assign pcl_wr  = STEP && FILE_WR && FILE_ADDR == csp_pkg::ADDR_PC_LOW;
	assign stat_wr = STEP && FILE_WR
		&& FILE_ADDR == csp_pkg::ADDR_ALU_STATUS;

	csp_pc_next u_pc_next
	(
		.pc       (st_r.pc),
		.op       (PC_OP),
		.lit      (LIT),
		.ret_addr (RET_ADDR),
		.pcl_wr   (pcl_wr),
		.pcl_data (FILE_WDATA),
		.pc_nxt   (pc_sel)
	);

	// Decoder fed from its own next value, not the state copy, so the tap has no cycle of lag behind config
	assign cfg_nxt = !RST_N ? csp_pkg::CFG_RESET
		: (STEP && CFG_LOAD) ? WREG[5:0] : st_r.cfg;

	csp_rate_dec u_rate_dec
	(
		.code (cfg_nxt[2:0]),
		.tap  (tap_dec)
	);

	always_comb
	begin
		st_nxt = st_r;
		if (STEP)
			st_nxt.pc = pc_sel;
		if (stat_wr)
		begin
			// Page bits always writable
			st_nxt.status[7:5] = FILE_WDATA[7:5];
			if (FLAG_OP == csp_pkg::CSP_FL_NONE)
				st_nxt.status[2:0] = FILE_WDATA[2:0];
			// Flag bits left to the result logic below
		end
		if (STEP)
		begin
			case (FLAG_OP)
				csp_pkg::CSP_FL_Z:
					st_nxt.status[csp_pkg::STAT_Z_BIT] =
						RESULT == 8'h00;
				csp_pkg::CSP_FL_ZCD:
				begin
					st_nxt.status[csp_pkg::STAT_Z_BIT] =
						RESULT == 8'h00;
					st_nxt.status[csp_pkg::STAT_DC_BIT] = DCARRY_IN;
					st_nxt.status[csp_pkg::STAT_C_BIT]  = CARRY_IN;
				end
				csp_pkg::CSP_FL_ROT:
					st_nxt.status[csp_pkg::STAT_C_BIT] = ROT_LEFT
						? ROT_OPERAND[7] : ROT_OPERAND[0];
				default:
					st_nxt.status = st_nxt.status;
			endcase
		end
		// Reset/sleep logic only; software writes never reach these
		if (TIMEOUT_SET)
			st_nxt.status[csp_pkg::STAT_TO_BIT] = 1'b1;
		else if (TIMEOUT_CLR)
			st_nxt.status[csp_pkg::STAT_TO_BIT] = 1'b0;
		if (POWERDOWN_SET)
			st_nxt.status[csp_pkg::STAT_PD_BIT] = 1'b1;
		else if (POWERDOWN_CLR)
			st_nxt.status[csp_pkg::STAT_PD_BIT] = 1'b0;
		st_nxt.cfg = cfg_nxt;
		st_nxt.tap = tap_dec;
		if (!RST_N)
		begin
			st_nxt.pc     = csp_pkg::PC_RESET_VECTOR;
			st_nxt.status = csp_pkg::STATUS_RESET;
			st_nxt.cfg    = csp_pkg::CFG_RESET;
			st_nxt.tap    = 8'h80;
		end
	end

	always_ff @(posedge CLK)
	begin
		st_r <= st_nxt;
	end

	// Config is not readable; only its decoded fields leave the block
	assign PC                  = st_r.pc;
	assign ALU_STATUS          = st_r.status;
	assign PC_LOW_READ         = st_r.pc[7:0];
	assign TIMER_SOURCE_SELECT = st_r.cfg[csp_pkg::CFG_SRC_BIT];
	assign TIMER_EDGE_SELECT   = st_r.cfg[csp_pkg::CFG_EDGE_BIT];
	assign PRESCALER_ASSIGN    = st_r.cfg[csp_pkg::CFG_ASSIGN_BIT];
	assign PRESCALE_TAP        = st_r.tap;
endmodule // csp_core

// file: test/csp_asserts.sv
// Checker: counter, low byte and config relations at csp_core ports.
// Assumes bind in the bench; controls only count while STEP is high.
`timescale 1ns/1ps
module csp_asserts
(
	input wire logic                CLK,
	input wire logic                RST_N,
	input wire logic                STEP,
	input wire csp_pkg::csp_pc_op_t PC_OP,
	input wire logic [8:0]          LIT,
	input wire logic                FILE_WR,
	input wire logic [4:0]          FILE_ADDR,
	input wire logic                CFG_LOAD,
	input wire logic [7:0]          WREG,
	input wire logic [8:0]          PC,
	input wire logic [7:0]          PC_LOW_READ,
	input wire logic                TIMER_SOURCE_SELECT,
	input wire logic [7:0]          PRESCALE_TAP
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_N);
	// File write to low byte overrides any branch
	sequence s_op(csp_pkg::csp_pc_op_t o); STEP && !FILE_WR && PC_OP == o;
	endsequence
	property p_inc; s_op(csp_pkg::CSP_PC_INC) |=> PC == $past(PC) + 9'h1;
	endproperty
	a_inc: assert property (p_inc)
		else $error("pc did not advance");
	property p_hold; !STEP |=> $stable(PC); endproperty
	a_hold: assert property (p_hold)
		else $error("pc moved without step");
	property p_jump; s_op(csp_pkg::CSP_PC_JUMP) |=> PC == $past(LIT); endproperty
	a_jump: assert property (p_jump)
		else $error("jump target wrong");
	property p_call; s_op(csp_pkg::CSP_PC_CALL) |=> PC == {1'b0, $past(LIT[7:0])};
	endproperty
	a_call: assert property (p_call)
		else $error("call target wrong");
	property p_pcl; STEP && FILE_WR && FILE_ADDR == 5'h02 |=> !PC[8]; endproperty
	a_pcl: assert property (p_pcl)
		else $error("computed jump left bit 8 set");
	property p_low; PC_LOW_READ == PC[7:0]; endproperty
	a_low: assert property (p_low)
		else $error("low byte view differs");
	property p_tap; STEP && CFG_LOAD |=> PRESCALE_TAP == 8'h01 << $past(WREG[2:0]);
	endproperty
	a_tap: assert property (p_tap)
		else $error("rate tap wrong");
	property p_src; STEP && CFG_LOAD |=> TIMER_SOURCE_SELECT == $past(WREG[5]);
	endproperty
	a_src: assert property (p_src)
		else $error("source select wrong");
endmodule // csp_asserts

// file: test/csp_core_bench.sv
// Bench: directed scenarios for csp_core.
// Assumes a 200 MHz clock; powerdown inputs held idle, timeout inputs driven only in t_status.
`timescale 1ns/1ps
module csp_core_bench;
	logic       CLK = 0, RST_N = 0, STEP = 0, CFG_LOAD = 0, FILE_WR = 0;
	logic       CARRY_IN = 0, DCARRY_IN = 0, ROT_LEFT = 0, TIMEOUT_SET = 0;
	logic       TIMEOUT_CLR = 0, POWERDOWN_SET = 0, POWERDOWN_CLR = 0;
	logic       TIMER_SOURCE_SELECT, TIMER_EDGE_SELECT, PRESCALER_ASSIGN;
	logic [8:0] LIT = 0, RET_ADDR = 0, PC;
	logic [7:0] WREG = 0, FILE_WDATA = 0, RESULT = 0, ROT_OPERAND = 0;
	logic [7:0] ALU_STATUS, PC_LOW_READ, PRESCALE_TAP;
	logic [4:0] FILE_ADDR = 0;
	int         err_count = 0, total_checks = 0, cycles = 0;
	csp_pkg::csp_pc_op_t   PC_OP = csp_pkg::CSP_PC_INC;
	csp_pkg::csp_flag_op_t FLAG_OP = csp_pkg::CSP_FL_NONE;
	csp_core i_csp_core (.*);
	always #2.5 CLK = ~CLK;
	task final_report();
		if (err_count == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// Hang guard: whole run is about 50 cycles
	always @(posedge CLK)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			err_count++;
			final_report();
		end
	end
	task chk(input logic [8:0] seen, input logic [8:0] exp, input string nm);
		total_checks++;
		if (seen !== exp)
		begin
			err_count++;
			$display("wrong value %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task e();
		@(posedge CLK);
	endtask
	// One step pulse; STEP, FILE_WR, CFG_LOAD and FLAG_OP drop at the taking edge
	task st();
		STEP <= 1;
		@(posedge CLK);
		{STEP, FILE_WR, CFG_LOAD} <= 3'h0;
		FLAG_OP <= csp_pkg::CSP_FL_NONE;
		#1;
	endtask
	task t_branch();
		e(); st(); chk(PC, 9'h000, "wrap");
		e(); PC_OP <= csp_pkg::CSP_PC_JUMP; LIT <= 9'h1ab; st();
		chk(PC, 9'h1ab, "jump");
		e(); PC_OP <= csp_pkg::CSP_PC_CALL; LIT <= 9'h1cd; st();
		chk(PC, 9'h0cd, "call");
		e(); PC_OP <= csp_pkg::CSP_PC_RET; RET_ADDR <= 9'h155; st();
		chk(PC, 9'h155, "ret");
		e(); PC_OP <= csp_pkg::CSP_PC_HOLD; st();
		chk(PC, 9'h155, "hold");
		e(); PC_OP <= csp_pkg::CSP_PC_JUMP; LIT <= 9'h100; FILE_WR <= 1;
		FILE_ADDR <= 5'h02; FILE_WDATA <= 8'hf0; st();
		chk(PC, 9'h0f0, "pcl");
		chk(PC_LOW_READ, 8'hf0, "pcl read");
	endtask
	task t_status();
		e(); FILE_WR <= 1; FILE_ADDR <= 5'h03; FILE_WDATA <= 8'he0; st();
		chk(ALU_STATUS, 8'hf8, "stat wr");
		e(); FILE_WR <= 1; FILE_WDATA <= 8'h00; CARRY_IN <= 1;
		FLAG_OP <= csp_pkg::CSP_FL_ZCD; st();
		chk(ALU_STATUS, 8'h1d, "stat alu");
		e(); FLAG_OP <= csp_pkg::CSP_FL_Z; RESULT <= 8'h01; st();
		chk(ALU_STATUS[2], 1'b0, "z clr");
		e(); TIMEOUT_CLR <= 1; e(); TIMEOUT_CLR <= 0; #1;
		chk(ALU_STATUS[4], 1'b0, "to clr");
		e(); {TIMEOUT_SET, TIMEOUT_CLR} <= 2'h3; e();
		{TIMEOUT_SET, TIMEOUT_CLR} <= 2'h0; #1;
		chk(ALU_STATUS[4], 1'b1, "to set");
		for (int i = 0; i < 2; i++)
		begin
			e(); FLAG_OP <= csp_pkg::CSP_FL_ROT; ROT_OPERAND <= 8'h80;
			ROT_LEFT <= i[0]; st();
			chk(ALU_STATUS[0], i[0], "rot carry");
		end
	endtask
	task t_cfg();
		for (int k = 0; k < 8; k++)
		begin
			e(); CFG_LOAD <= 1; WREG <= {2'h3, k[2:0] ^ 3'h5, k[2:0]}; st();
			chk(PRESCALE_TAP, 8'h01 << k, "tap");
			chk({TIMER_SOURCE_SELECT, TIMER_EDGE_SELECT, PRESCALER_ASSIGN},
				k[2:0] ^ 3'h5, "sel");
		end
	endtask
	initial
	begin
		repeat (8) e();
		RST_N <= 1;
		#1;
		chk(PC, 9'h1ff, "pc rst");
		chk(ALU_STATUS[7:5], 3'h0, "page rst");
		chk(PRESCALE_TAP, 8'h80, "tap rst");
		chk({TIMER_SOURCE_SELECT, TIMER_EDGE_SELECT, PRESCALER_ASSIGN},
			3'h7, "cfg rst");
		t_branch();
		t_status();
		t_cfg();
		final_report();
	end
endmodule // csp_core_bench
bind csp_core csp_asserts i_csp_asserts (.*);
